// >>> shared/acs_pkg.sv
// Constants, register map and carrier types of the converter calibration sequencer
package acs_pkg;

    // ------------------------------------------------------------
    // Converter structure
    // ------------------------------------------------------------
    localparam int         SMP_W     = 12;        // Bits per bank sample
    localparam int         NUM_CORES = 3;         // Two active cores and one spare
    localparam logic [SMP_W-1:0] MIDCODE = 12'h000; // Two's-complement midcode
    localparam logic [1:0] CORE_A    = 2'h0;
    localparam logic [1:0] CORE_B    = 2'h1;
    localparam logic [1:0] CORE_C    = 2'h2;

    // ------------------------------------------------------------
    // Register map, byte offsets
    // ------------------------------------------------------------
    localparam int         ADDR_W      = 6;
    localparam logic [5:0] OFS_CTRL    = 6'h00;
    localparam logic [5:0] OFS_TRIG    = 6'h04;
    localparam logic [5:0] OFS_DELAY   = 6'h08;
    localparam logic [5:0] OFS_STATUS  = 6'h0c;
    localparam logic [5:0] OFS_TRIM0   = 6'h10;   // Four trims at 0x10..0x1c
    localparam int         NUM_TRIMS   = 4;
    localparam logic [8:0] CTRL_RST    = 9'h001;  // Calibration enabled only
    localparam logic [7:0] SLEEP_RST   = 8'h10;
    localparam logic [7:0] WAKE_RST    = 8'h04;
    localparam int         SOFT_TRIG_BIT = 0;
    localparam int         DLY_SHIFT   = 8;       // One delay step is 256 cycles
    localparam int         CNT_W       = 16;
    localparam int         TRIG_SYNC   = 3;

    // Factory trim defaults, arbitrary neutral values
    localparam logic [NUM_TRIMS*SMP_W-1:0] TRIM_DEFAULT = 48'h800_800_800_800;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic single_input_sel;          // 0: input A, 1: input B
        logic single_channel;
        logic bg_offset_cal_enable;
        logic fg_offset_cal_enable;
        logic low_power_switch_select;   // 0: automatic, 1: user paced
        logic low_power_bg_enable;
        logic background_cal_enable;
        logic cal_trigger_source_select; // 1: pin, 0: software bit
        logic cal_enable;
    } acs_ctrl_t;

    typedef struct packed {
        logic [7:0] spare_wake_settle_delay;
        logic [7:0] spare_sleep_delay;
    } acs_delay_t;

    // One core sample: two interleaved banks
    typedef struct packed {
        logic [SMP_W-1:0] bank1;
        logic [SMP_W-1:0] bank0;
    } acs_core_smp_t;

    typedef enum logic [6:0] {
        ST_IDLE     = 7'b0000001,
        ST_FG_CAL   = 7'b0000010,
        ST_FG_OFS   = 7'b0000100,
        ST_BG_SLEEP = 7'b0001000,
        ST_BG_WAKE  = 7'b0010000,
        ST_BG_CAL   = 7'b0100000,
        ST_BG_SWAP  = 7'b1000000
    } acs_state_t;

endpackage

// >>> hw/acs_sequencer.sv
// Calibration sequencer for a three-core, six-bank interleaved converter
`timescale 1ns/100ps
// Overview of operation
// - Foreground calibration forces outputs to midcode
// - Background mode keeps converting through calibration
// - Six banks, three cores, two-way interleaved
// - Dual: A samples A, B samples B
// - Spare core periodically replaces cores A, B
// - Each pass trims linearity, gain, offset
// - Power-up foreground calibration; host waits
// - Trigger pin or soft bit for foreground; soft bit only for background
// - Background rotation: spare replaces, displaced calibrates
// - Low-power mode keeps offline cores powered down
// - Sleep delay paces automatic low-power switching
// - Wake delay lets woken core settle
// - Switch-select picks automatic or user-paced switching
// - Input-buffer offset calibration is separate step
// - Foreground offset correction runs exactly once
// - Background offset correction runs continuously
// - Offset result written into trims; writes blocked
// - Trims hold factory defaults, readable and writable
module acs_sequencer (
    input  wire logic                       sys_clk_in,
    input  wire logic                       rst_in,
    // Avalon-MM slave
    input  wire logic [acs_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    output logic [31:0]                     avs_readdata,
    output logic                            avs_waitrequest,
    // Trigger pin
    input  wire logic                       cal_trigger_pin_in,
    // Per-core bank samples and analog calibration engine
    input  acs_pkg::acs_core_smp_t          core_data_in [acs_pkg::NUM_CORES],
    input  wire logic [2:0]                 cal_done_in,
    input  wire logic                       ofs_done_in,
    input  wire logic [4*acs_pkg::SMP_W-1:0] ofs_trim_in,
    // Converter control
    output logic [2:0]                      cal_req_out,
    output logic [2:0]                      core_power_out,
    output logic [2:0]                      core_input_sel_out,
    output logic                            ofs_req_out,
    output logic [4*acs_pkg::SMP_W-1:0]     input_offset_trim_out,
    output logic                            foreground_cal_done_out,
    // Converted output samples
    output acs_pkg::acs_core_smp_t          sample_a_out,
    output acs_pkg::acs_core_smp_t          sample_b_out
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    acs_pkg::acs_ctrl_t                ctrl;
    acs_pkg::acs_delay_t               dly;
    acs_pkg::acs_state_t               state;
    acs_pkg::acs_state_t               next_state;
    logic [acs_pkg::SMP_W-1:0]         trim [acs_pkg::NUM_TRIMS];
    logic [acs_pkg::TRIG_SYNC-1:0]     pin_sync;
    logic [2:0]                        done_meta;
    logic [2:0]                        done_s;
    logic [2:0]                        ofs_sync;
    logic                              soft_trig;
    logic                              trig_evt;
    logic                              ofs_evt;
    logic                              bus_acc;
    logic                              wr_acc;
    logic [1:0]                        slot_core [2];
    logic [1:0]                        spare;
    logic                              rot_slot;
    logic [acs_pkg::CNT_W-1:0]         cnt;
    logic [acs_pkg::CNT_W-1:0]         sleep_cyc;
    logic [acs_pkg::CNT_W-1:0]         wake_cyc;
    logic                              ofs_busy;
    logic                              fg_active;
    logic                              bg_active;
    logic [31:0]                       next_rdata;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Pin, engine done lines, offset done; third stage only for edges
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pin_sync  <= '0;
            done_meta <= '0;
            done_s    <= '0;
            ofs_sync  <= '0;
        end else begin
            pin_sync  <= {pin_sync[1:0], cal_trigger_pin_in};
            done_meta <= cal_done_in;
            done_s    <= done_meta;
            ofs_sync  <= {ofs_sync[1:0], ofs_done_in};
        end
    end

    // Trigger source choice: pin rising edge or soft bit write
    assign trig_evt = ctrl.cal_trigger_source_select ?
                      (pin_sync[1] & ~pin_sync[2]) : soft_trig;
    assign ofs_evt  = ofs_sync[1] & ~ofs_sync[2];

    // ------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------
    // Each access waits one cycle, then completes
    assign bus_acc = (avs_read | avs_write) & avs_waitrequest;
    assign wr_acc  = avs_write & ~avs_waitrequest;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~bus_acc;
        end
    end

    // Read mux, unmapped addresses read zero
    always_comb begin
        next_rdata = '0;
        case (avs_address)
            acs_pkg::OFS_CTRL:   next_rdata[8:0]  = ctrl;
            acs_pkg::OFS_DELAY:  next_rdata[15:0] = dly;
            acs_pkg::OFS_STATUS: next_rdata[14:0] = {rot_slot, slot_core[1],
                                     slot_core[0], spare, state,
                                     foreground_cal_done_out};
            default: begin
                for (int i = 0; i < acs_pkg::NUM_TRIMS; i++) begin
                    if (avs_address == acs_pkg::OFS_TRIM0 + 6'(4 * i)) begin
                        next_rdata[acs_pkg::SMP_W-1:0] = trim[i];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            avs_readdata <= '0;
        end else if (bus_acc && avs_read) begin
            avs_readdata <= next_rdata;
        end
    end

    // Control and delay registers
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ctrl <= acs_pkg::CTRL_RST;
            dly  <= {acs_pkg::WAKE_RST, acs_pkg::SLEEP_RST};
        end else if (wr_acc) begin
            if (avs_address == acs_pkg::OFS_CTRL) begin
                ctrl <= avs_writedata[8:0];
            end
            if (avs_address == acs_pkg::OFS_DELAY) begin
                dly <= avs_writedata[15:0];
            end
        end
    end

    // Self-clearing software trigger, honoured only when enabled
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            soft_trig <= 1'b0;
        end else begin
            soft_trig <= wr_acc && avs_address == acs_pkg::OFS_TRIG &&
                         avs_writedata[acs_pkg::SOFT_TRIG_BIT];
        end
    end

    // ------------------------------------------------------------
    // Offset trim registers
    // ------------------------------------------------------------
    assign ofs_busy = state == acs_pkg::ST_FG_OFS ||
                      (bg_active && ctrl.bg_offset_cal_enable);

    // Engine result wins; software writes dropped while offset cal runs
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < acs_pkg::NUM_TRIMS; i++) begin
                trim[i] <= acs_pkg::TRIM_DEFAULT[i*acs_pkg::SMP_W +: acs_pkg::SMP_W];
            end
        end else if (ofs_busy && ofs_evt) begin
            for (int i = 0; i < acs_pkg::NUM_TRIMS; i++) begin
                trim[i] <= ofs_trim_in[i*acs_pkg::SMP_W +: acs_pkg::SMP_W];
            end
        end else if (wr_acc && !ofs_busy) begin
            for (int i = 0; i < acs_pkg::NUM_TRIMS; i++) begin
                if (avs_address == acs_pkg::OFS_TRIM0 + 6'(4 * i)) begin
                    trim[i] <= avs_writedata[acs_pkg::SMP_W-1:0];
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        for (int i = 0; i < acs_pkg::NUM_TRIMS; i++) begin
            input_offset_trim_out[i*acs_pkg::SMP_W +: acs_pkg::SMP_W] <= trim[i];
        end
    end

    // ------------------------------------------------------------
    // Sequencer state machine
    // ------------------------------------------------------------
    assign fg_active = state == acs_pkg::ST_FG_CAL || state == acs_pkg::ST_FG_OFS;
    assign bg_active = !fg_active && state != acs_pkg::ST_IDLE;
    assign sleep_cyc = acs_pkg::CNT_W'({dly.spare_sleep_delay, 8'h00});
    assign wake_cyc  = acs_pkg::CNT_W'({dly.spare_wake_settle_delay, 8'h00});

    always_comb begin
        next_state = state;
        case (state)
            acs_pkg::ST_IDLE: begin
                if (trig_evt && ctrl.cal_enable && done_s == 3'b000) begin
                    if (ctrl.background_cal_enable && !ctrl.cal_trigger_source_select) begin
                        next_state = acs_pkg::ST_BG_CAL;
                    end else if (!ctrl.background_cal_enable) begin
                        next_state = acs_pkg::ST_FG_CAL;
                    end
                end
            end
            acs_pkg::ST_FG_CAL: begin
                if (done_s == 3'b111) begin
                    next_state = ctrl.fg_offset_cal_enable ?
                                 acs_pkg::ST_FG_OFS : acs_pkg::ST_IDLE;
                end
            end
            acs_pkg::ST_FG_OFS: begin
                if (ofs_evt) begin
                    next_state = acs_pkg::ST_IDLE;
                end
            end
            acs_pkg::ST_BG_CAL: begin
                if (done_s[spare]) begin
                    next_state = acs_pkg::ST_BG_SWAP;
                end
            end
            acs_pkg::ST_BG_SWAP: begin
                if (!ctrl.background_cal_enable) begin
                    next_state = acs_pkg::ST_IDLE;
                end else if (ctrl.low_power_bg_enable) begin
                    next_state = acs_pkg::ST_BG_SLEEP;
                end else if (!done_s[spare]) begin
                    next_state = acs_pkg::ST_BG_CAL;
                end
            end
            acs_pkg::ST_BG_SLEEP: begin
                if (!ctrl.background_cal_enable) begin
                    next_state = acs_pkg::ST_IDLE;
                end else if (ctrl.low_power_switch_select ? trig_evt
                                                           : cnt >= sleep_cyc) begin
                    next_state = acs_pkg::ST_BG_WAKE;
                end
            end
            acs_pkg::ST_BG_WAKE: begin
                if (cnt >= wake_cyc && !done_s[spare]) begin
                    next_state = acs_pkg::ST_BG_CAL;
                end
            end
            default: next_state = acs_pkg::ST_IDLE;
        endcase
    end

    // Reset enters foreground calibration at once
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state <= acs_pkg::ST_FG_CAL;
        end else begin
            state <= next_state;
        end
    end

    // Delay counter restarts on each state change
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || next_state != state) begin
            cnt <= '0;
        end else if (cnt != '1) begin
            cnt <= cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Core rotation
    // ------------------------------------------------------------
    // Calibrated spare takes the slot, displaced core becomes spare
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            slot_core[0] <= acs_pkg::CORE_A;
            slot_core[1] <= acs_pkg::CORE_B;
            spare        <= acs_pkg::CORE_C;
            rot_slot     <= 1'b0;
        end else if (state == acs_pkg::ST_BG_CAL && next_state == acs_pkg::ST_BG_SWAP) begin
            slot_core[rot_slot] <= spare;
            spare               <= slot_core[rot_slot];
            rot_slot            <= ~rot_slot;
        end
    end

    // Done flag clears on foreground start, sets when foreground ends (after the offset step if enabled)
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            foreground_cal_done_out <= 1'b0;
        end else if (fg_active && next_state == acs_pkg::ST_IDLE) begin
            foreground_cal_done_out <= 1'b1;
        end else if (next_state == acs_pkg::ST_FG_CAL) begin
            foreground_cal_done_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Converter control outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cal_req_out    <= '1;
            core_power_out <= '1;
            ofs_req_out    <= 1'b0;
        end else begin
            cal_req_out <= '0;
            if (next_state == acs_pkg::ST_FG_CAL) begin
                cal_req_out <= 3'b111;
            end else if (next_state == acs_pkg::ST_BG_CAL) begin
                cal_req_out[spare] <= 1'b1;
            end
            core_power_out <= '1;
            if (next_state == acs_pkg::ST_BG_SLEEP) begin
                core_power_out[spare] <= 1'b0;
            end
            ofs_req_out <= next_state == acs_pkg::ST_FG_OFS ||
                           (next_state != acs_pkg::ST_IDLE && !fg_active &&
                            next_state != acs_pkg::ST_FG_CAL &&
                            ctrl.bg_offset_cal_enable);
        end
    end

    // Input select per core, dual or single channel
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            core_input_sel_out <= '0;
        end else begin
            for (int c = 0; c < acs_pkg::NUM_CORES; c++) begin
                core_input_sel_out[c] <= ctrl.single_channel ? ctrl.single_input_sel
                                       : (slot_core[1] == 2'(c));
            end
        end
    end

    // ------------------------------------------------------------
    // Output samples
    // ------------------------------------------------------------
    // Two banks per core pass through together; midcode in foreground
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || fg_active) begin
            sample_a_out <= {acs_pkg::MIDCODE, acs_pkg::MIDCODE};
            sample_b_out <= {acs_pkg::MIDCODE, acs_pkg::MIDCODE};
        end else begin
            sample_a_out <= core_data_in[slot_core[0]];
            sample_b_out <= core_data_in[slot_core[1]];
        end
    end

endmodule // acs_sequencer

// >>> tb/acs_sequencer_properties.sv
// Port checks for the calibration sequencer
`timescale 1ns/100ps
module acs_sequencer_properties (
    input wire logic                   sys_clk_in,
    input wire logic                   rst_in,
    input wire logic                   avs_read,
    input wire logic                   avs_write,
    input wire logic                   avs_waitrequest,
    input wire logic [2:0]             cal_req_out,
    input wire logic [2:0]             core_power_out,
    input wire logic                   ofs_req_out,
    input wire logic                   foreground_cal_done_out,
    input wire acs_pkg::acs_core_smp_t sample_a_out,
    input wire acs_pkg::acs_core_smp_t sample_b_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    // Access taken, then a single low waitrequest cycle
    sequence seq_take;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence seq_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    a_bus_answer: assert property (seq_take |=> seq_answer)
        else $error("access not answered in one cycle");
    a_bus_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
        else $error("answer without request");
    a_fg_midcode: assert property ((cal_req_out == 3'h7 && $past(cal_req_out) == 3'h7)
        |-> (sample_a_out == '0 && sample_b_out == '0)) else $error("output not midcode");
    a_done_clear: assert property (cal_req_out == 3'h7 |-> !foreground_cal_done_out)
        else $error("done set during calibration");
    a_done_end: assert property ($rose(foreground_cal_done_out)
        |-> (cal_req_out == 3'h0 && !ofs_req_out)) else $error("done before work ended");
    a_power_cal: assert property ($fell(rst_in) |-> cal_req_out == 3'h7)
        else $error("no calibration after reset");
    a_bg_single: assert property (cal_req_out != 3'h7 |-> $onehot0(cal_req_out))
        else $error("two cores offline");
    a_sleep_nocal: assert property ((~core_power_out & cal_req_out) == 3'h0)
        else $error("sleeping core calibrated");
endmodule // acs_sequencer_properties

// >>> tb/acs_sequencer_bench.sv
// Self-checking bench for the calibration sequencer
`timescale 1ns/100ps
module acs_sequencer_bench;
    logic                   sys_clk_in;
    logic                   rst_in;
    logic [5:0]             avs_address;
    logic                   avs_read;
    logic                   avs_write;
    logic [31:0]            avs_writedata;
    logic [31:0]            avs_readdata;
    logic                   avs_waitrequest;
    logic                   cal_trigger_pin_in;
    acs_pkg::acs_core_smp_t core_data_in [acs_pkg::NUM_CORES];
    logic [2:0]             cal_done_in;
    logic                   ofs_done_in;
    logic [47:0]            ofs_trim_in;
    logic [2:0]             cal_req_out;
    logic [2:0]             core_power_out;
    logic [2:0]             core_input_sel_out;
    logic                   ofs_req_out;
    logic                   ofs_prev;
    logic [47:0]            input_offset_trim_out;
    logic                   foreground_cal_done_out;
    acs_pkg::acs_core_smp_t sample_a_out;
    acs_pkg::acs_core_smp_t sample_b_out;
    logic [31:0]            exp_q [$];
    logic [11:0]            tv;
    int                     num_errors;
    int                     cmp_count;
    int                     ofs_runs;
    int                     n;

    acs_sequencer uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .cal_trigger_pin_in(cal_trigger_pin_in), .core_data_in(core_data_in),
        .cal_done_in(cal_done_in), .ofs_done_in(ofs_done_in), .ofs_trim_in(ofs_trim_in),
        .cal_req_out(cal_req_out), .core_power_out(core_power_out),
        .core_input_sel_out(core_input_sel_out), .ofs_req_out(ofs_req_out),
        .input_offset_trim_out(input_offset_trim_out),
        .foreground_cal_done_out(foreground_cal_done_out),
        .sample_a_out(sample_a_out), .sample_b_out(sample_b_out));

    // Clock, 4 ns period
    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end

    // Engine stand-in: answers each request a cycle later, counts offset runs
    always @(posedge sys_clk_in) begin
        cal_done_in <= rst_in ? 3'h0 : cal_req_out;
        ofs_done_in <= rst_in ? 1'b0 : ofs_req_out;
        ofs_prev    <= ofs_req_out;
        if (ofs_req_out === 1'b1 && ofs_prev === 1'b0) ofs_runs <= ofs_runs + 1;
    end

    // Read monitor: pairs each answered read with the oldest note
    always @(posedge sys_clk_in) begin
        if (avs_waitrequest === 1'b0 && avs_read === 1'b1) begin
            if (exp_q.size() == 0) num_errors++;
            else check_reg(avs_readdata, exp_q.pop_front());
        end
    end

    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t read %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_port(input logic [47:0] got, input logic [47:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t port %h exp %h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One bus access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] adr, input logic [31:0] wd,
                       input logic [31:0] ed);
        int k;
        k = 0;
        avs_address   <= adr;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= wd;
        if (!wr) exp_q.push_back(ed);
        do begin
            @(posedge sys_clk_in);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 40);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (k >= 40) begin
            num_errors++;
            complete_run();
        end
        @(posedge sys_clk_in);
    endtask

    task automatic wait_req(input logic [2:0] want);
        n = 0;
        while (cal_req_out !== want && n < 3000) begin
            @(posedge sys_clk_in);
            n++;
        end
        check_port({45'h0, cal_req_out}, {45'h0, want});
        if (n >= 3000) complete_run();
    endtask

    task automatic wait_done;
        repeat (3) @(posedge sys_clk_in);
        n = 0;
        while (foreground_cal_done_out !== 1'b1 && n < 3000) begin
            @(posedge sys_clk_in);
            n++;
        end
        check_port({47'h0, foreground_cal_done_out}, 48'h1);
        if (n >= 3000) complete_run();
    endtask

    // Main sequence
    initial begin
        void'($urandom(75950));
        rst_in = 1'b1;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        {cal_trigger_pin_in, cal_done_in, ofs_done_in, ofs_trim_in} = '0;
        core_data_in = '{default: '0};
        {num_errors, cmp_count, ofs_runs} = '0;
        repeat (12) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        check_port({45'h0, cal_req_out}, 48'h7);
        check_port({sample_a_out, sample_b_out}, 48'h0);
        wait_done();
        bus(1'b0, acs_pkg::OFS_CTRL, '0, 32'h1);
        bus(1'b0, acs_pkg::OFS_DELAY, '0, 32'h0410);
        bus(1'b0, acs_pkg::OFS_STATUS, '0, 32'h1203);
        for (int i = 0; i < 4; i++) bus(1'b0, 6'(acs_pkg::OFS_TRIM0 + 4 * i), '0, 32'h800);
        bus(1'b0, 6'h20, '0, 32'h0);
        tv = 12'($urandom);
        bus(1'b1, 6'h14, {20'h0, tv}, '0);
        bus(1'b0, 6'h14, '0, {20'h0, tv});
        check_port(input_offset_trim_out, {24'h800800, tv, 12'h800});
        foreach (core_data_in[i]) core_data_in[i] <= acs_pkg::acs_core_smp_t'(24'($urandom));
        repeat (3) @(posedge sys_clk_in);
        check_port({sample_a_out, sample_b_out}, {core_data_in[0], core_data_in[1]});
        check_port({45'h0, core_input_sel_out}, 48'h2);
        bus(1'b1, acs_pkg::OFS_CTRL, 32'h181, '0);
        repeat (3) @(posedge sys_clk_in);
        check_port({45'h0, core_input_sel_out}, 48'h7);
        ofs_trim_in <= 48'({$urandom, $urandom});
        bus(1'b1, acs_pkg::OFS_CTRL, 32'h21, '0);
        bus(1'b1, acs_pkg::OFS_TRIG, 32'h1, '0);
        wait_done();
        check_port(48'(ofs_runs), 48'h1);
        @(posedge sys_clk_in);
        check_port(input_offset_trim_out, ofs_trim_in);
        bus(1'b0, acs_pkg::OFS_TRIM0, '0, {20'h0, ofs_trim_in[11:0]});
        bus(1'b1, acs_pkg::OFS_CTRL, 32'h3, '0);
        bus(1'b1, acs_pkg::OFS_TRIG, 32'h1, '0);
        repeat (8) @(posedge sys_clk_in);
        check_port({45'h0, cal_req_out}, 48'h0);
        cal_trigger_pin_in <= 1'b1;
        @(posedge sys_clk_in);
        cal_trigger_pin_in <= 1'b0;
        wait_req(3'h7);
        wait_done();
        bus(1'b1, acs_pkg::OFS_CTRL, 32'h5, '0);
        bus(1'b1, acs_pkg::OFS_TRIG, 32'h1, '0);
        wait_req(3'h4);
        check_port({sample_a_out, sample_b_out}, {core_data_in[0], core_data_in[1]});
        wait_req(3'h1);
        repeat (2) @(posedge sys_clk_in);
        check_port({24'h0, sample_a_out}, {24'h0, core_data_in[2]});
        bus(1'b1, acs_pkg::OFS_DELAY, 32'h0101, '0);
        bus(1'b1, acs_pkg::OFS_CTRL, 32'hd, '0);
        n = 0;
        while (core_power_out === 3'h7 && n < 3000) begin
            @(posedge sys_clk_in);
            n++;
        end
        n = 0;
        while (core_power_out !== 3'h7 && n < 3000) begin
            @(posedge sys_clk_in);
            n++;
        end
        check_port(48'(n >= 256 && n <= 272), 48'h1);
        n = 0;
        while (cal_req_out === 3'h0 && n < 3000) begin
            @(posedge sys_clk_in);
            n++;
        end
        check_port(48'(n >= 256 && n <= 272), 48'h1);
        complete_run();
    end
endmodule // acs_sequencer_bench

bind acs_sequencer acs_sequencer_properties u_props (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .cal_req_out(cal_req_out),
    .core_power_out(core_power_out), .ofs_req_out(ofs_req_out),
    .foreground_cal_done_out(foreground_cal_done_out),
    .sample_a_out(sample_a_out), .sample_b_out(sample_b_out));
